// ===== hdl/shift_option_defs.svh
`ifndef SHIFT_OPTION_DEFS_SVH
`define SHIFT_OPTION_DEFS_SVH
`define WORD_W        36
`define PAIR_W        (2*`WORD_W)
`define CNT_W         7
`define FLD_LO        16
`define FLD_HI        27
`define DIR_BIT       27
`define SEL_BIT       26
`define CNT_HI        25
`define CNT_LO        19
`define CNT_ZERO      7'h00
`define CNT_ONE       7'h01
`define WORD_ZERO     36'h000000000
`define DBL_ZERO      72'h000000000000000000
`endif

// ===== hdl/shift_option_pkg.sv
`include "shift_option_defs.svh"
package shift_option_pkg;
  typedef logic [`WORD_W-1:0] word_t;
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_WAIT  = 2'b01,
    ST_SHIFT = 2'b10,
    ST_DONE  = 2'b11
  } seq_state_e;
endpackage

// ===== hdl/secondary_shift_option_decoder.sv
`timescale 1ns/100ps
`include "shift_option_defs.svh"
module secondary_shift_option_decoder
  import shift_option_pkg::*;
(
  input  wire logic  i_mclk,
  input  wire logic  i_resetn,
  input  wire logic  i_instr_valid,
  input  wire word_t i_instr,
  input  wire logic  i_is_transfer,
  input  wire logic  i_field_used,
  input  wire logic  i_primary_done,
  input  wire word_t i_acc,
  input  wire word_t i_mq,
  output logic       o_busy,
  output logic       o_done,
  output logic       o_acc_we,
  output logic       o_mq_we,
  output word_t      o_acc,
  output word_t      o_mq
);

  // Sequencer state and the command captured when it is taken
  seq_state_e            state;
  seq_state_e            next_state;
  logic                  dir_left;
  logic                  dbl;
  logic [`CNT_W-1:0]     count;
  word_t                 acc;
  word_t                 mq;

  // Decode and sequencing terms
  wire [`FLD_HI:`FLD_LO] field;
  wire                   f_left;
  wire                   f_dbl;
  wire [`CNT_W-1:0]      f_count;
  wire                   f_enable;
  wire                   f_nonzero;
  wire                   f_go;
  wire                   in_idle;
  wire                   in_wait;
  wire                   in_shift;
  wire                   in_done;
  wire                   take_cmd;
  wire                   take_result;
  wire                   step;
  wire                   mq_step;
  wire                   last;
  wire [`CNT_W-1:0]      next_count;

  // Shift datapath, A in the upper half of the pair
  wire [`PAIR_W-1:0]     pair;
  wire [`PAIR_W-1:0]     next_pair;
  wire word_t            next_acc;
  wire word_t            next_mq;

  // Field decode straight from the word; index registers never reach this path
  assign field       = i_instr[`FLD_HI:`FLD_LO];
  assign f_left      = field[`DIR_BIT];
  assign f_dbl       = field[`SEL_BIT];
  // The spare bits below the count are deliberately left unread
  assign f_count     = field[`CNT_HI:`CNT_LO];
  assign f_enable    = ~i_is_transfer & ~i_field_used;
  assign f_nonzero   = (f_count != `CNT_ZERO);
  assign f_go        = i_instr_valid & f_enable & f_nonzero;

  // State decodes shared by the register updates and the output strobes
  assign in_idle     = (state == ST_IDLE);
  assign in_wait     = (state == ST_WAIT);
  assign in_shift    = (state == ST_SHIFT);
  assign in_done     = (state == ST_DONE);
  // Commands are taken only when idle, so a valid during a sequence is dropped
  assign take_cmd    = in_idle & f_go;
  // Sampling here rather than at decode lets the shift act on the primary result
  assign take_result = in_wait & i_primary_done;
  // Q is clocked only in the double-length mode and otherwise keeps the primary result
  assign step        = in_shift;
  assign mq_step     = in_shift & dbl;
  assign last        = (count == `CNT_ONE);
  assign next_count  = count - `CNT_ONE;

  // One place per cycle in both modes, as the standalone shifts do: zero fill,
  // no rotate, bits pushed off either end are lost
  assign pair        = {acc, mq};
  assign next_acc    = next_pair[`PAIR_W-1:`WORD_W];
  assign next_mq     = next_pair[`WORD_W-1:0];

  genvar b;
  generate
    for (b = 0; b < `PAIR_W; b = b + 1) begin : g_bit
      wire from_lo;
      wire from_hi;
      wire shifted;

      // Left shift pulls from the bit below
      if (b == 0) begin : g_lo_end
        assign from_lo = 1'h0;
      end else if (b == `WORD_W) begin : g_lo_join
        // A alone must not pick up the top of Q
        assign from_lo = dbl & pair[b-1];
      end else begin : g_lo_mid
        assign from_lo = pair[b-1];
      end

      // Right shift pulls from the bit above
      if (b == `PAIR_W - 1) begin : g_hi_end
        assign from_hi = 1'h0;
      end else begin : g_hi_mid
        assign from_hi = pair[b+1];
      end

      assign shifted = dir_left ? from_lo : from_hi;

      // Q moves only in the double-length mode
      if (b < `WORD_W) begin : g_q
        assign next_pair[b] = dbl ? shifted : pair[b];
      end else begin : g_a
        assign next_pair[b] = shifted;
      end
    end
  endgenerate

  // Wait for the primary, then run the count down one place per cycle
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (f_go) begin
          next_state = ST_WAIT;
        end
      end

      ST_WAIT: begin
        if (i_primary_done) begin
          next_state = ST_SHIFT;
        end
      end

      ST_SHIFT: begin
        if (last) begin
          next_state = ST_DONE;
        end
      end

      ST_DONE: begin
        next_state = ST_IDLE;
      end

      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // Reset abandons any sequence in flight; the primary result is not written back
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Command fields are frozen at decode; later words cannot disturb a running shift
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      dir_left <= 1'h0;
      dbl      <= 1'h0;
    end else if (take_cmd) begin
      dir_left <= f_left;
      dbl      <= f_dbl;
    end
  end

  // Only the literal count is loaded, never an indexed one
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      count <= `CNT_ZERO;
    end else if (take_cmd) begin
      count <= f_count;
    end else if (step) begin
      count <= next_count;
    end
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      acc <= `WORD_ZERO;
    end else if (take_result) begin
      acc <= i_acc;
    end else if (step) begin
      acc <= next_acc;
    end
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      mq <= `WORD_ZERO;
    end else if (take_result) begin
      mq <= i_mq;
    end else if (mq_step) begin
      mq <= next_mq;
    end
  end

  // Strobes decode from state, the Q strobe also from the double-length mode; the data itself comes from registers
  assign o_busy   = ~in_idle;
  assign o_done   = in_done;
  assign o_acc_we = in_done;
  assign o_mq_we  = in_done & dbl;
  assign o_acc    = acc;
  assign o_mq     = mq;

endmodule

// ===== tb/shift_option_props.sv
`timescale 1ns/100ps
module shift_option_props (
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic i_instr_valid,
  input wire logic o_busy,
  input wire logic o_done,
  input wire logic o_acc_we,
  input wire logic o_mq_we
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_resetn);
  sequence finish_s; o_done ##1 !o_busy; endsequence
  chk_we_with_done: assert property (o_acc_we == o_done) else $error("we");
  chk_mq_we_gate: assert property (o_mq_we |-> o_done) else $error("mq");
  chk_done_busy: assert property (o_done |-> o_busy) else $error("db");
  chk_done_pulse: assert property (o_done |=> !o_done) else $error("dp");
  chk_idle_after: assert property (o_done |-> finish_s) else $error("ia");
  chk_busy_holds: assert property (o_busy && !o_done |=> o_busy) else $error("bh");
  chk_no_early: assert property (!$past(o_busy) |-> !o_done) else $error("ne");
  chk_start_cause: assert property ($rose(o_busy) |-> $past(i_instr_valid)) else $error("sc");
endmodule
bind secondary_shift_option_decoder shift_option_props chk_u (.*);

// ===== tb/testbench.sv
`timescale 1ns/100ps
`define CHK(a,b) begin comparisons++; if ((a)!==(b)) begin n_fail++; \
  $display("Error %0t %h %h", $time, a, b); end end
module testbench import shift_option_pkg::*; ;
  logic  i_mclk = 0, i_resetn = 0, i_instr_valid = 0;
  logic  i_is_transfer = 0, i_field_used = 0, i_primary_done = 0;
  logic  o_busy, o_done, o_acc_we, o_mq_we;
  word_t i_instr = '0, i_acc = '0, i_mq = '0, o_acc, o_mq;
  int    n_fail = 0, comparisons = 0;
  logic [31:0] r = 32'hd4ce04db;
  secondary_shift_option_decoder dut_u (
    .i_mclk         (i_mclk),
    .i_resetn       (i_resetn),
    .i_instr_valid  (i_instr_valid),
    .i_instr        (i_instr),
    .i_is_transfer  (i_is_transfer),
    .i_field_used   (i_field_used),
    .i_primary_done (i_primary_done),
    .i_acc          (i_acc),
    .i_mq           (i_mq),
    .o_busy         (o_busy),
    .o_done         (o_done),
    .o_acc_we       (o_acc_we),
    .o_mq_we        (o_mq_we),
    .o_acc          (o_acc),
    .o_mq           (o_mq)
  );
  initial forever #12.5 i_mclk = ~i_mclk;
  function logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Single mode must not leak bits into Q, so A is shifted on its own
  function automatic logic [71:0] ref_sh(word_t a, word_t q, word_t w);
    logic [71:0] d;
    word_t s;
    d = w[27] ? {a, q} << w[25:19] : {a, q} >> w[25:19];
    s = w[27] ? a << w[25:19] : a >> w[25:19];
    return w[26] ? d : {s, q};
  endfunction
  task automatic run(word_t w, logic t, logic f, int gap);
    int k;
    logic en;
    logic [71:0] e;
    en = !t && !f && w[25:19] != 7'h00;
    @(negedge i_mclk);
    {i_instr, i_is_transfer, i_field_used, i_instr_valid} = {w, t, f, 1'b1};
    @(negedge i_mclk);
    // While busy a second word with valid set must be dropped
    {i_instr, i_instr_valid} = {~w, en && gap > 0};
    `CHK(o_busy, en)
    repeat (gap) @(negedge i_mclk);
    if (gap > 0) i_instr_valid = 0;
    r = lfsr(r);
    i_acc = {r[3:0], r};
    r = lfsr(r);
    i_mq = {r, r[3:0]};
    i_primary_done = 1;
    e = ref_sh(i_acc, i_mq, w);
    @(negedge i_mclk) i_primary_done = 0;
    // Bound covers the largest count of 127 places
    for (k = 0; k < 130 && o_done !== 1'b1; k++) @(negedge i_mclk);
    `CHK(k, en ? w[25:19] : 130)
    if (en) begin
      `CHK(o_acc, e[71:36])
      `CHK(o_acc_we, 1'b1)
      `CHK(o_mq_we, w[26])
      `CHK(o_mq, e[35:0])
    end
  endtask
  task end_of_test;
    $display("n_fail %0d comparisons %0d", n_fail, comparisons);
    if (n_fail == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (3) @(negedge i_mclk);
    `CHK({o_busy, o_done, o_acc_we, o_mq_we, o_acc, o_mq}, 76'h0)
    i_resetn = 1;
    run(36'h00fff0000, 0, 0, 0);
    run(36'h000080000, 0, 0, 2);
    run(36'h00fff0000, 1, 0, 0);
    run(36'h00fff0000, 0, 1, 0);
    run(36'h00c070000, 0, 0, 0);
    // A reset while a long shift still waits for the primary result abandons it and clears the outputs
    @(negedge i_mclk);
    {i_instr, i_is_transfer, i_field_used, i_instr_valid} = {36'h00fff0000, 3'h1};
    @(negedge i_mclk) i_instr_valid = 0;
    `CHK(o_busy, 1'b1)
    i_resetn = 0;
    @(negedge i_mclk);
    `CHK({o_busy, o_done, o_acc_we, o_mq_we, o_acc, o_mq}, 76'h0)
    i_resetn = 1;
    run(36'h004010000, 0, 0, 1);
    repeat (40) begin
      r = lfsr(r);
      run({r[3:0], r}, r[5] & r[6], r[7] & r[8], r[1:0]);
    end
    end_of_test;
  end
  initial begin
    #500us;
    n_fail++;
    end_of_test;
  end
endmodule
